// [src/address_break_unit.sv]
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module address_break_unit
#(
	parameter int         APB_ADDR_W = 8,
	parameter logic [7:0] SWI_OPCODE = 8'h00
)
(
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [APB_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [15:0]           cpu_addr,
	input  wire logic                  cpu_addr_valid,
	input  wire logic                  cpu_opcode_cycle,
	input  wire logic                  cpu_wait_mode,
	input  wire logic                  monitor_mode,
	output logic                       force_swi,
	output logic      [7:0]            insn_override,
	output logic      [15:0]           vector_hi_addr,
	output logic      [15:0]           vector_lo_addr,
	output logic                       break_state,
	output logic                       flag_clear_allow,
	output logic                       timer_halt,
	output logic                       watchdog_disable,
	output logic                       irq
);
	import break_unit_pkg::*;

	// decoding shared by read and write paths
	function automatic reg_sel_e decode(input logic [APB_ADDR_W-1:0] a);
		logic [7:0] a8;
		a8 = a[7:0];
		if ((a >> 8) != '0)
			return SEL_NONE;
		unique case (a8)
			OFS_STATUS_CONTROL: return SEL_STATUS_CONTROL;
			OFS_ADDR_HIGH:      return SEL_ADDR_HIGH;
			OFS_ADDR_LOW:       return SEL_ADDR_LOW;
			OFS_STATUS_REG:     return SEL_STATUS_REG;
			OFS_FLAG_CONTROL:   return SEL_FLAG_CONTROL;
			OFS_AUXILIARY:      return SEL_AUXILIARY;
			OFS_IRQ_STATUS:     return SEL_IRQ_STATUS;
			OFS_IRQ_MASK:       return SEL_IRQ_MASK;
			default:            return SEL_NONE;
		endcase
	endfunction

	// the decoder reads a full low address byte, so narrower buses cannot work
	if (APB_ADDR_W < 8)
		$error("APB_ADDR_W below 8 cannot reach the register map");

	logic [7:0]  addr_high_q;
	logic [7:0]  addr_low_q;
	logic        active_q;
	logic        pend_q;
	logic        armed_q;
	logic        stop_wait_q;
	logic        clear_enable_q;
	logic        dis_watchdog_q;
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_mask_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic        force_swi_q;
	logic [15:0] vector_hi_q;
	logic [15:0] vector_lo_q;
	logic        allow_q;
	logic        timer_halt_q;
	logic        watchdog_q;
	logic        irq_q;

	reg_sel_e    sel;
	logic        acc;
	logic        wr;
	logic        hit;
	logic        boundary;
	logic        take;
	logic        sw_set;
	logic        sw_clr;
	logic        clr_ok;

	// apb: one wait state, write lands on the completing edge only
	assign sel = decode(paddr);
	assign acc = psel & penable & pready_q;
	assign wr  = acc & pwrite;

	// 16-bit compare against both bytes together
	assign hit      = armed_q & cpu_addr_valid & ~active_q
	                & (cpu_addr == {addr_high_q, addr_low_q});
	assign boundary = cpu_addr_valid & cpu_opcode_cycle;
	// opcode hit replaces the fetched opcode; pending breaks wait for the next fetch
	assign take     = boundary & ~active_q & (hit | pend_q);

	assign sw_set = wr & (sel == SEL_STATUS_CONTROL) & pwdata[BIT_ACTIVE];
	assign sw_clr = wr & (sel == SEL_STATUS_CONTROL) & ~pwdata[BIT_ACTIVE];
	// status flags except the irq status bits may only be cleared outside break or with clear-enable
	assign clr_ok = ~active_q | clear_enable_q;

	// apb handshake and read data
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end
		else
		begin
			pready_q  <= psel & penable & ~pready_q;
			pslverr_q <= psel & penable & ~pready_q & (sel == SEL_NONE);
			if (psel & penable & ~pready_q & ~pwrite)
			begin
				prdata_q <= 32'h0000_0000;
				unique case (sel)
					SEL_STATUS_CONTROL: prdata_q[BIT_ACTIVE] <= active_q;
					SEL_ADDR_HIGH:      prdata_q[7:0] <= addr_high_q;
					SEL_ADDR_LOW:       prdata_q[7:0] <= addr_low_q;
					SEL_STATUS_REG:     prdata_q[BIT_STOP_WAIT] <= stop_wait_q;
					SEL_FLAG_CONTROL:   prdata_q[BIT_CLEAR_ENABLE] <= clear_enable_q;
					SEL_AUXILIARY:      prdata_q[BIT_DIS_WATCHDOG] <= dis_watchdog_q;
					SEL_IRQ_STATUS:     prdata_q[1:0] <= irq_stat_q;
					SEL_IRQ_MASK:       prdata_q[1:0] <= irq_mask_q;
					SEL_NONE:           prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// break address bytes; a new address re-arms the comparator
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			addr_high_q <= RST_ADDR_BYTE;
			addr_low_q  <= RST_ADDR_BYTE;
		end
		else if (wr)
		begin
			if (sel == SEL_ADDR_HIGH)
				addr_high_q <= pwdata[7:0];
			if (sel == SEL_ADDR_LOW)
				addr_low_q <= pwdata[7:0];
		end
	end

	// disarmed by each break so a stale address cannot retrigger
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			armed_q <= 1'b0;                                     // avoids a break at 0000 after reset
		else if (wr & ((sel == SEL_ADDR_HIGH) | (sel == SEL_ADDR_LOW)))
			armed_q <= 1'b1;
		else if (take)
			armed_q <= 1'b0;
	end

	// software request held until the next instruction boundary
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			pend_q <= 1'b0;
		else if (take)
			pend_q <= 1'b0;
		else if (sw_set & ~active_q)
			pend_q <= 1'b1;
		else if (sw_clr)
			pend_q <= 1'b0;
	end

	// break state; a take in the clearing cycle wins
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			active_q <= 1'b0;
		else if (take)
			active_q <= 1'b1;
		else if (sw_clr)
			active_q <= 1'b0;
	end

	// stop/wait flag: set wins, software clears by writing zero
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			stop_wait_q <= 1'b0;
		else if (take & cpu_wait_mode)
			stop_wait_q <= 1'b1;
		else if (wr & (sel == SEL_STATUS_REG) & ~pwdata[BIT_STOP_WAIT] & clr_ok)
			stop_wait_q <= 1'b0;
	end

	// flag control and auxiliary configuration
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			clear_enable_q <= 1'b0;
			dis_watchdog_q <= 1'b0;
		end
		else if (wr)
		begin
			if (sel == SEL_FLAG_CONTROL)
				clear_enable_q <= pwdata[BIT_CLEAR_ENABLE];
			if (sel == SEL_AUXILIARY)
				dis_watchdog_q <= pwdata[BIT_DIS_WATCHDOG];
		end
	end

	// interrupt status, write one to clear, set wins; mask is plain storage
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			irq_stat_q <= RST_IRQ_BITS;
			irq_mask_q <= RST_IRQ_BITS;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (wr & (sel == SEL_IRQ_STATUS) & pwdata[i])
					irq_stat_q[i] <= 1'b0;
			end
			if (take)
				irq_stat_q[BIT_IRQ_BREAK] <= 1'b1;
			if (take & cpu_wait_mode)
				irq_stat_q[BIT_IRQ_WAIT] <= 1'b1;
			if (wr & (sel == SEL_IRQ_MASK))
				irq_mask_q <= pwdata[1:0];
		end
	end

	// break entry to the sequencer: opcode override and vector, one cycle
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			force_swi_q <= 1'b0;
			vector_hi_q <= VEC_NORMAL_HI;
			vector_lo_q <= VEC_NORMAL_LO;
		end
		else
		begin
			force_swi_q <= take;
			if (take)
			begin
				vector_hi_q <= monitor_mode ? VEC_MONITOR_HI : VEC_NORMAL_HI;
				vector_lo_q <= monitor_mode ? VEC_MONITOR_LO : VEC_NORMAL_LO;
			end
		end
	end

	// side effects of the break state, one cycle behind it
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			allow_q      <= 1'b1;
			timer_halt_q <= 1'b0;
			watchdog_q   <= 1'b0;
			irq_q        <= 1'b0;
		end
		else
		begin
			allow_q      <= clr_ok;
			timer_halt_q <= active_q;
			watchdog_q   <= active_q & monitor_mode & dis_watchdog_q;
			irq_q        <= |(irq_stat_q & irq_mask_q);
		end
	end

	// port mapping; five break registers plus aux and interrupt words
	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
	assign force_swi        = force_swi_q;
	assign insn_override    = SWI_OPCODE;
	assign vector_hi_addr   = vector_hi_q;
	assign vector_lo_addr   = vector_lo_q;
	assign break_state      = active_q;
	assign flag_clear_allow = allow_q;
	assign timer_halt       = timer_halt_q;
	assign watchdog_disable = watchdog_q;
	assign irq              = irq_q;

	// opcode-location hit: override on the very next cycle
	sequence s_opcode_hit;
		boundary && hit;
	endsequence
	property p_opcode_break;
		@(posedge clk_sys) disable iff (!rst_n)
		s_opcode_hit |=> force_swi_q && active_q;
	endproperty
	a_opcode_break: assert property (p_opcode_break)
		else $error("opcode match did not force the break");

	// operand hit takes no break and leaves the comparator armed
	property p_operand_defer;
		@(posedge clk_sys) disable iff (!rst_n)
		(cpu_addr_valid && !cpu_opcode_cycle && hit) |=> !force_swi_q && armed_q;
	endproperty
	a_operand_defer: assert property (p_operand_defer)
		else $error("operand match broke before instruction end");

	// software request becomes pending, then is taken at a boundary
	sequence s_sw_request;
		sw_set && !active_q && !boundary;
	endsequence
	property p_soft_pending;
		@(posedge clk_sys) disable iff (!rst_n)
		s_sw_request |=> pend_q;
	endproperty
	a_soft_pending: assert property (p_soft_pending)
		else $error("software request not held pending");

	property p_soft_take;
		@(posedge clk_sys) disable iff (!rst_n)
		(pend_q && boundary && !active_q) |=> force_swi_q ##1 !force_swi_q;
	endproperty
	a_soft_take: assert property (p_soft_take)
		else $error("pending break not taken at instruction start");

	// no address break without a fresh address since the last one; software breaks are excluded
	property p_no_rebreak;
		@(posedge clk_sys) disable iff (!rst_n)
		(force_swi_q && !$past(pend_q)) |-> $past(armed_q) && !armed_q;
	endproperty
	a_no_rebreak: assert property (p_no_rebreak)
		else $error("address break taken while disarmed");

	property p_vector;
		@(posedge clk_sys) disable iff (!rst_n)
		force_swi_q |-> vector_hi_q == ($past(monitor_mode) ? VEC_MONITOR_HI : VEC_NORMAL_HI)
		             && vector_lo_q == vector_hi_q + 16'h0001;
	endproperty
	a_vector: assert property (p_vector)
		else $error("wrong break vector");

	property p_override;
		@(posedge clk_sys) disable iff (!rst_n)
		force_swi_q |-> insn_override == SWI_OPCODE && active_q;
	endproperty
	a_override: assert property (p_override)
		else $error("break without opcode override");

	property p_timer_halt;
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(active_q) |=> timer_halt_q;
	endproperty
	a_timer_halt: assert property (p_timer_halt)
		else $error("timer not halted in break");

	property p_watchdog;
		@(posedge clk_sys) disable iff (!rst_n)
		watchdog_q |-> $past(active_q) && $past(monitor_mode) && $past(dis_watchdog_q);
	endproperty
	a_watchdog: assert property (p_watchdog)
		else $error("watchdog disabled outside monitor break");

	property p_wait_flag;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && cpu_wait_mode) |=> stop_wait_q && irq_stat_q[BIT_IRQ_WAIT];
	endproperty
	a_wait_flag: assert property (p_wait_flag)
		else $error("wait-mode break did not set stop/wait flag");

	property p_flag_protect;
		@(posedge clk_sys) disable iff (!rst_n)
		$fell(stop_wait_q) |-> $past(clr_ok);
	endproperty
	a_flag_protect: assert property (p_flag_protect)
		else $error("status flag cleared while protected");

	property p_stays_clear;
		@(posedge clk_sys) disable iff (!rst_n)
		($fell(stop_wait_q) && active_q) ##1 !take [*3] |-> !stop_wait_q;
	endproperty
	a_stays_clear: assert property (p_stays_clear)
		else $error("cleared flag came back without a break");

endmodule // address_break_unit
`default_nettype wire

// [src/break_unit_pkg.sv]
// Summary of operation
// - Request a break when the CPU address equals the programmed break address.
// - Software writing one to the active flag also requests a break.
// - A software requested break is taken just before the next instruction.
// - Taking a break forces the software interrupt opcode into the instruction register.
// - Break vector is FFFC/FFFD normally, FEFC/FEFD in monitor mode.
// - Opcode address match: that instruction runs only after the break routine.
// - Operand address match: no break is taken and the comparator stays armed.
// - Clearing the flag without a new address gives no further break.
// - In break state, status flags clear only when clear-enable is set; the irq status bits here clear on a write of one regardless.
// - The timer counter is halted while a break is in effect.
// - Break in monitor mode disables the watchdog when the aux bit is set.
// - Eight registers: status/control, address high, address low, status, flag control, auxiliary, irq status, irq mask.
// - A break taken in wait mode sets the stop/wait flag.
// - A latch cleared during break state stays cleared after leaving it.
package break_unit_pkg;

	// register byte offsets, one aligned word each
	localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_ADDR_HIGH      = 8'h04;
	localparam logic [7:0] OFS_ADDR_LOW       = 8'h08;
	localparam logic [7:0] OFS_STATUS_REG     = 8'h0C;
	localparam logic [7:0] OFS_FLAG_CONTROL   = 8'h10;
	localparam logic [7:0] OFS_AUXILIARY      = 8'h14;
	localparam logic [7:0] OFS_IRQ_STATUS     = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK       = 8'h1C;

	// field positions
	localparam int BIT_ACTIVE       = 6;
	localparam int BIT_STOP_WAIT    = 1;
	localparam int BIT_CLEAR_ENABLE = 7;
	localparam int BIT_DIS_WATCHDOG = 0;
	localparam int BIT_IRQ_BREAK    = 0;
	localparam int BIT_IRQ_WAIT     = 1;

	// reset values
	localparam logic [7:0] RST_ADDR_BYTE = 8'h00;
	localparam logic [1:0] RST_IRQ_BITS  = 2'h0;

	// break vectors
	localparam logic [15:0] VEC_NORMAL_HI  = 16'hFFFC;
	localparam logic [15:0] VEC_NORMAL_LO  = 16'hFFFD;
	localparam logic [15:0] VEC_MONITOR_HI = 16'hFEFC;
	localparam logic [15:0] VEC_MONITOR_LO = 16'hFEFD;

	// register select codes
	typedef enum logic [3:0] {
		SEL_STATUS_CONTROL,
		SEL_ADDR_HIGH,
		SEL_ADDR_LOW,
		SEL_STATUS_REG,
		SEL_FLAG_CONTROL,
		SEL_AUXILIARY,
		SEL_IRQ_STATUS,
		SEL_IRQ_MASK,
		SEL_NONE
	} reg_sel_e;

endpackage

// [test/address_break_unit_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module address_break_unit_bench;
	import break_unit_pkg::*;
	localparam logic [7:0] SWI_VAL = 8'h83; // arbitrary opcode value
	logic        clk_sys, rst_n, psel, penable, pwrite, pslverr, pready;
	logic        cpu_wait_mode, monitor_mode, force_swi, break_state, flag_clear_allow;
	logic        timer_halt, watchdog_disable, irq, cpu_addr_valid, cpu_opcode_cycle;
	logic [7:0]  paddr, insn_override, insn_reg_q;
	logic [31:0] pwdata, prdata;
	logic [15:0] cpu_addr, vector_hi_addr, vector_lo_addr;
	int          mismatches, n_tests;

	address_break_unit #(.APB_ADDR_W(8), .SWI_OPCODE(SWI_VAL)) i_dut (.clk_sys(clk_sys),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_addr(cpu_addr), .cpu_addr_valid(cpu_addr_valid),
		.cpu_opcode_cycle(cpu_opcode_cycle), .cpu_wait_mode(cpu_wait_mode),
		.monitor_mode(monitor_mode), .force_swi(force_swi), .insn_override(insn_override),
		.vector_hi_addr(vector_hi_addr), .vector_lo_addr(vector_lo_addr),
		.break_state(break_state), .flag_clear_allow(flag_clear_allow),
		.timer_halt(timer_halt), .watchdog_disable(watchdog_disable), .irq(irq));
	cpu_bus_model i_cpu (.clk_sys(clk_sys), .force_swi(force_swi),
		.insn_override(insn_override), .cpu_addr(cpu_addr), .cpu_addr_valid(cpu_addr_valid),
		.cpu_opcode_cycle(cpu_opcode_cycle), .insn_reg_q(insn_reg_q));

	// 100 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; bounded wait for pready, one idle edge after release
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		// a lost answer is counted and the run goes on to the closing report
		if (pready !== 1'b1)
		begin
			mismatches++;
			$display("[FAIL] %0t bus transfer never answered", $time);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		check(r, exp);
		check({31'h0, e}, {31'h0, eexp});
	endtask

	// one cpu bus cycle, then look at the break request during the following cycle
	task automatic cyc_chk(input logic [15:0] a, input logic op, input logic take);
		i_cpu.cyc(a, op);
		@(posedge clk_sys);
		check({31'h0, force_swi}, {31'h0, take});
	endtask

	task automatic wait2();
		repeat (2) @(posedge clk_sys);
	endtask

	// hang guard
	initial
	begin
		#200000;
		mismatches++;
		$display("[FAIL] %0t run did not finish", $time);
		give_verdict();
	end

	// main sequence
	initial
	begin
		mismatches = 0;
		n_tests = 0;
		rst_n = 1'b0;
		{psel, penable, pwrite, cpu_wait_mode, monitor_mode} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		check({break_state, flag_clear_allow, timer_halt, irq}, 32'h4);
		check({vector_hi_addr, vector_lo_addr}, {VEC_NORMAL_HI, VEC_NORMAL_LO});
		rd(OFS_STATUS_CONTROL, 32'h0, 1'b0);
		rd(OFS_ADDR_HIGH, 32'h0, 1'b0);
		rd(OFS_ADDR_LOW, 32'h0, 1'b0);
		rd(OFS_STATUS_REG, 32'h0, 1'b0);
		rd(OFS_FLAG_CONTROL, 32'h0, 1'b0);
		rd(8'h20, 32'h0, 1'b1);
		// address match; half matches and an operand cycle must not break
		wr(OFS_IRQ_MASK, 32'h3);
		wr(OFS_ADDR_HIGH, 32'h12);
		wr(OFS_ADDR_LOW, 32'h34);
		rd(OFS_ADDR_HIGH, 32'h12, 1'b0);
		rd(OFS_ADDR_LOW, 32'h34, 1'b0);
		rd(OFS_IRQ_MASK, 32'h3, 1'b0);
		cyc_chk(16'h1235, 1'b1, 1'b0);
		cyc_chk(16'h1334, 1'b1, 1'b0);
		cyc_chk(16'h1234, 1'b0, 1'b0);
		cyc_chk(16'h1234, 1'b1, 1'b1);
		check({vector_hi_addr, vector_lo_addr}, {VEC_NORMAL_HI, VEC_NORMAL_LO});
		check({24'h0, insn_override}, {24'h0, SWI_VAL});
		@(posedge clk_sys);
		check({24'h0, insn_reg_q}, {24'h0, SWI_VAL});
		check({break_state, timer_halt, irq}, 32'h7);
		rd(OFS_STATUS_CONTROL, 32'h40, 1'b0);
		wr(OFS_IRQ_STATUS, 32'h1);
		wait2();
		check({31'h0, irq}, 32'h0);
		// flag cleared, address untouched: no second break
		wr(OFS_STATUS_CONTROL, 32'h0);
		wait2();
		check({break_state, timer_halt}, 32'h0);
		cyc_chk(16'h1234, 1'b1, 1'b0);
		wr(OFS_ADDR_LOW, 32'h56);
		cyc_chk(16'h1256, 1'b1, 1'b1);
		wr(OFS_STATUS_CONTROL, 32'h0);
		// software request in monitor and wait mode waits for the next opcode fetch
		monitor_mode <= 1'b1;
		cpu_wait_mode <= 1'b1;
		wr(OFS_AUXILIARY, 32'h1);
		rd(OFS_AUXILIARY, 32'h1, 1'b0);
		wr(OFS_STATUS_CONTROL, 32'h40);
		wait2();
		check({31'h0, force_swi}, 32'h0);
		cyc_chk(16'h0100, 1'b0, 1'b0);
		cyc_chk(16'h0101, 1'b1, 1'b1);
		check({vector_hi_addr, vector_lo_addr}, {VEC_MONITOR_HI, VEC_MONITOR_LO});
		wait2();
		check({31'h0, watchdog_disable}, 32'h1);
		cpu_wait_mode <= 1'b0;
		rd(OFS_STATUS_REG, 32'h2, 1'b0);
		// the earlier address break left its bit set, this one adds the wait bit
		rd(OFS_IRQ_STATUS, 32'h3, 1'b0);
		// flag clearing in break state needs the clear enable
		check({31'h0, flag_clear_allow}, 32'h0);
		wr(OFS_STATUS_REG, 32'h0);
		rd(OFS_STATUS_REG, 32'h2, 1'b0);
		wr(OFS_FLAG_CONTROL, 32'h80);
		rd(OFS_FLAG_CONTROL, 32'h80, 1'b0);
		wait2();
		check({31'h0, flag_clear_allow}, 32'h1);
		wr(OFS_STATUS_REG, 32'h0);
		wr(OFS_STATUS_CONTROL, 32'h0);
		wait2();
		rd(OFS_STATUS_REG, 32'h0, 1'b0);
		check({break_state, watchdog_disable}, 32'h0);
		// mid-run reset: outputs back to idle, comparator disarmed until an address write
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		check({break_state, flag_clear_allow, timer_halt, watchdog_disable, irq}, 32'h8);
		rd(OFS_FLAG_CONTROL, 32'h0, 1'b0);
		cyc_chk(16'h0000, 1'b1, 1'b0);
		wr(OFS_ADDR_HIGH, 32'h0);
		cyc_chk(16'h0000, 1'b1, 1'b1);
		wait2();
		// mask cleared by reset keeps the interrupt low although the status bit is set
		check({break_state, timer_halt, irq}, 32'h6);
		rd(OFS_IRQ_STATUS, 32'h1, 1'b0);
		give_verdict();
	end
endmodule // address_break_unit_bench
`default_nettype wire

// [test/cpu_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
// cpu side: issues single bus cycles and loads its instruction register on a forced break
module cpu_bus_model
(
	input  wire logic        clk_sys,
	input  wire logic        force_swi,
	input  wire logic [7:0]  insn_override,
	output logic      [15:0] cpu_addr,
	output logic             cpu_addr_valid,
	output logic             cpu_opcode_cycle,
	output logic      [7:0]  insn_reg_q
);
	// idle bus at time zero
	initial
	begin
		cpu_addr = 16'h0000;
		cpu_addr_valid = 1'b0;
		cpu_opcode_cycle = 1'b0;
		insn_reg_q = 8'h00;
	end

	// a forced break replaces the fetched opcode, so the matched instruction waits
	always @(posedge clk_sys)
	begin
		if (force_swi === 1'b1)
			insn_reg_q <= insn_override;
	end

	// one bus cycle; the address is inverted afterwards so no stale match lingers
	task automatic cyc(input logic [15:0] a, input logic op);
		cpu_addr <= a;
		cpu_addr_valid <= 1'b1;
		cpu_opcode_cycle <= op;
		@(posedge clk_sys);
		cpu_addr_valid <= 1'b0;
		cpu_opcode_cycle <= 1'b0;
		cpu_addr <= ~a;
	endtask
endmodule // cpu_bus_model
`default_nettype wire
